// ==== flvic_consts.svh ====
// Purpose: Constants of the four-level vectored interrupt controller
// Assumes: Machine cycle of four clocks, flags indexed by arbitration rank
// Notes:   Source word is {wake, in_reg_b, bit position, vector}
// Overview of operation
// RQ1 - No call while equal-or-higher level is serviced
// RQ2 - Call only in instruction's final machine cycle
// RQ3 - Withhold call on enable/priority write or service exit
// RQ4 - Requests re-polled each cycle, never remembered
// RQ5 - Vectoring clears the timer overflow flag
// RQ6 - External flag cleared on vectoring only when edge triggered
// RQ7 - Uart and watchdog flags survive vectoring
// RQ8 - Call pushes program counter, loads source vector
// RQ9 - Fixed vector per source, eight-byte spacing
// RQ10 - Service exit marks current routine finished
// RQ11 - Plain subroutine exit leaves in-service state alone
// RQ12 - Level is high bit over low bit
// RQ13 - Preempt only by strictly higher level
// RQ14 - Highest programmed level wins among simultaneous requests
// RQ15 - Fixed ranking breaks ties within one level
// RQ16 - Priority bits share position with enable bit
// RQ17 - Only listed sources wake from power-down
// RQ18 - External pins sampled at phase three
// RQ19 - Timer flags polled in following machine cycle
// RQ20 - Inserted call lasts four machine cycles
// RQ21 - Single-source response within twelve machine cycles
// RQ22 - Enabled external interrupt wakes from power-down or idle
// RQ23 - Global enable gates every source
// RQ24 - Software can set and clear every flag; in level mode the code ignores writes to the external flags
// RQ25 - One in-service bit per level, exit clears highest
`ifndef FLVIC_CONSTS_SVH
`define FLVIC_CONSTS_SVH
`define FLVIC_NFLAG 14
`define FLVIC_NSRC 13
`define FLVIC_FLAG_EXT_A 0
`define FLVIC_FLAG_TIMER_A 3
`define FLVIC_FLAG_CONV 5
`define FLVIC_FLAG_EXT_B 6
`define FLVIC_FLAG_TIMER_B 9
`define FLVIC_FLAG_UART_RX 11
`define FLVIC_FLAG_UART_TX 13
`define FLVIC_GLOBAL_EN_BIT 7
`define FLVIC_CLK_PER_MC 4
`define FLVIC_CALL_MC 4
`define FLVIC_C3_PHASE 2
`define FLVIC_SRC_0 {1'h1, 1'h0, 3'h0, 16'h0003}
`define FLVIC_SRC_1 {1'h1, 1'h0, 3'h5, 16'h002B}
`define FLVIC_SRC_2 {1'h0, 1'h1, 3'h4, 16'h0053}
`define FLVIC_SRC_3 {1'h0, 1'h0, 3'h1, 16'h000B}
`define FLVIC_SRC_4 {1'h0, 1'h1, 3'h0, 16'h0033}
`define FLVIC_SRC_5 {1'h0, 1'h0, 3'h6, 16'h005B}
`define FLVIC_SRC_6 {1'h1, 1'h0, 3'h2, 16'h0013}
`define FLVIC_SRC_7 {1'h1, 1'h1, 3'h1, 16'h003B}
`define FLVIC_SRC_8 {1'h1, 1'h1, 3'h2, 16'h0063}
`define FLVIC_SRC_9 {1'h0, 1'h0, 3'h3, 16'h001B}
`define FLVIC_SRC_10 {1'h1, 1'h1, 3'h3, 16'h0043}
`define FLVIC_SRC_11 {1'h0, 1'h0, 3'h4, 16'h0023}
`define FLVIC_SRC_12 {1'h0, 1'h1, 3'h5, 16'h0073}
`endif

// ==== flvic_pkg.sv ====
// Purpose: Types of the four-level vectored interrupt controller
// Assumes: Constants live in flvic_consts.svh
// Notes:   Flag vectors are indexed by arbitration rank
package flvic_pkg;
    typedef enum logic [1:0] {FLVIC_IDLE = 2'h0, FLVIC_CALL = 2'h1} flvic_fsm_e;
    typedef struct packed {
        logic        wake;
        logic        in_b;
        logic [2:0]  pos;
        logic [15:0] vec;
    } flvic_src_s;
    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] lo_a;
        logic [7:0] hi_a;
        logic [7:0] lo_b;
        logic [7:0] hi_b;
    } flvic_sfr_s;
    typedef struct packed {
        logic last_cycle;
        logic blocking_instr;
        logic service_exit;
        logic power_down;
        logic idle;
    } flvic_core_s;
    typedef struct packed {
        flvic_fsm_e  fsm;
        logic [3:0]  phase;
        logic [1:0]  sync_a;
        logic [1:0]  sync_b;
        logic        samp_a;
        logic        samp_b;
        logic [13:0] flags;
        logic [13:0] sample;
        logic [3:0]  in_service;
        logic [3:0]  call_cnt;
        logic [1:0]  call_level;
        logic [15:0] call_vector;
        logic        call_start;
        logic        call_active;
        logic        wake_up;
    } flvic_state_s;
endpackage : flvic_pkg

// ==== flvic_ctrl.sv ====
// Purpose: Four-level vectored interrupt controller for an 8-bit core
// Assumes: Core signals final machine cycle and enable/priority writes
// Notes:   Stack push on call_start and pop on exit are done by the core
`include "flvic_consts.svh"
module flvic_ctrl #(
    parameter int CLK_PER_MC = `FLVIC_CLK_PER_MC,
    parameter int CALL_MC    = `FLVIC_CALL_MC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ext_irq_pin_a,
    input  wire logic                    ext_irq_pin_b,
    input  wire logic                    ext_a_edge_mode,
    input  wire logic                    ext_b_edge_mode,
    input  wire logic                    converter_rc_clock,
    input  wire flvic_pkg::flvic_sfr_s   sfr,
    input  wire flvic_pkg::flvic_core_s  core,
    input  wire logic [13:0]             hw_event,
    input  wire logic [13:0]             sw_flag_wr,
    input  wire logic [13:0]             sw_flag_data,
    output logic [13:0]                  flags,
    output logic                         call_start,
    output logic                         call_active,
    output logic [15:0]                  call_vector,
    output logic [3:0]                   in_service,
    output logic                         wake_up
);
    localparam int NF = `FLVIC_NFLAG;
    localparam int NS = `FLVIC_NSRC;
    localparam int IA = `FLVIC_FLAG_EXT_A;
    localparam int IB = `FLVIC_FLAG_EXT_B;
    localparam int TA = `FLVIC_FLAG_TIMER_A;
    localparam int TB = `FLVIC_FLAG_TIMER_B;
    localparam int RX = `FLVIC_FLAG_UART_RX;
    localparam int TX = `FLVIC_FLAG_UART_TX;
    localparam int CALL_TOTAL = CLK_PER_MC * CALL_MC;
    localparam logic [3:0] PH_LAST = 4'(CLK_PER_MC - 1);
    localparam logic [3:0] PH_C3   = 4'(`FLVIC_C3_PHASE);
    localparam logic [3:0] CNT_END = 4'(CALL_MC - 1);
    localparam logic [NF-1:0] EXT_MASK = (NF'(1) << IA) | (NF'(1) << IB);

    // Phase and call counters are four bits wide
    generate
        if (CLK_PER_MC < 4 || CLK_PER_MC > 16 || CALL_MC < 1 || CALL_MC > 16) begin : g_bad
            $error("flvic_ctrl: CLK_PER_MC must be 4..16 and CALL_MC 1..16");
        end
    endgenerate

    flvic_pkg::flvic_state_s s_reg;
    flvic_pkg::flvic_state_s s_next;
    flvic_pkg::flvic_src_s   info;
    flvic_pkg::flvic_src_s   win_info;
    logic [NS-1:0]           req_src;
    logic [NS-1:0]           live_src;
    logic [NF-1:0]           flags_v;
    logic [3:0]              isr_v;
    logic [2:0]              top_w;
    logic [1:0]              lvl;
    logic [1:0]              win_lvl;
    logic                    win_found;
    logic                    en;
    logic                    global_en;
    logic                    wake_pd;
    logic                    wake_any;
    logic                    mc_end;
    logic                    c3;
    logic                    grant;

    function automatic flvic_pkg::flvic_src_s src_info(input logic [3:0] idx);
        flvic_pkg::flvic_src_s r;
        r = '0;
        case (idx)
            4'h0: r = `FLVIC_SRC_0;
            4'h1: r = `FLVIC_SRC_1;
            4'h2: r = `FLVIC_SRC_2;
            4'h3: r = `FLVIC_SRC_3;
            4'h4: r = `FLVIC_SRC_4;
            4'h5: r = `FLVIC_SRC_5;
            4'h6: r = `FLVIC_SRC_6;
            4'h7: r = `FLVIC_SRC_7;
            4'h8: r = `FLVIC_SRC_8;
            4'h9: r = `FLVIC_SRC_9;
            4'hA: r = `FLVIC_SRC_10;
            4'hB: r = `FLVIC_SRC_11;
            4'hC: r = `FLVIC_SRC_12;
            default: r = '0;
        endcase
        return r;
    endfunction : src_info

    // Returns {valid, level} of the highest in-service bit
    function automatic logic [2:0] top_of(input logic [3:0] isr);
        logic [2:0] t;
        t = 3'h0;
        for (int k = 0; k < 4; k++) begin
            if (isr[k]) begin
                t = {1'b1, 2'(k)};
            end
        end
        return t;
    endfunction : top_of

    assign mc_end    = (s_reg.phase == PH_LAST);
    assign c3        = (s_reg.phase == PH_C3);
    assign global_en = sfr.en_a[`FLVIC_GLOBAL_EN_BIT];
    assign top_w     = top_of(s_reg.in_service);

    // Both uart flags share one source
    always_comb begin
        req_src      = s_reg.sample[NS-1:0];
        req_src[RX]  = s_reg.sample[RX] | s_reg.sample[TX];
        live_src     = s_reg.flags[NS-1:0];
        live_src[RX] = s_reg.flags[RX] | s_reg.flags[TX];
    end

    // Descending scan so a lower rank wins a tie of equal level
    always_comb begin
        info      = '0;
        win_info  = '0;
        win_lvl   = 2'h0;
        win_found = 1'b0;
        en        = 1'b0;
        lvl       = 2'h0;
        wake_pd   = 1'b0;
        wake_any  = 1'b0;
        for (int i = NS - 1; i >= 0; i--) begin
            info = src_info(4'(i));
            en   = (info.in_b ? sfr.en_b[info.pos] : sfr.en_a[info.pos]) & global_en; // [RQ23]
            lvl  = info.in_b ? {sfr.hi_b[info.pos], sfr.lo_b[info.pos]}
                             : {sfr.hi_a[info.pos], sfr.lo_a[info.pos]}; // [RQ12] [RQ16]
            if (en && req_src[i] && (!win_found || lvl >= win_lvl)) begin // [RQ14] [RQ15]
                win_found = 1'b1;
                win_lvl   = lvl;
                win_info  = info;
            end
            if (en && live_src[i]) begin
                wake_any = 1'b1;
                if (info.wake || (i == `FLVIC_FLAG_CONV && converter_rc_clock)) begin // [RQ17]
                    wake_pd = 1'b1;
                end
            end
        end
    end

    // Poll once per machine cycle, at its last clock, on last cycle's sample
    assign grant = mc_end && (s_reg.fsm == flvic_pkg::FLVIC_IDLE) && win_found // [RQ4] [RQ21]
                   && core.last_cycle // [RQ2]
                   && !core.blocking_instr && !core.service_exit // [RQ3]
                   && (!top_w[2] || win_lvl > top_w[1:0]); // [RQ1] [RQ13]

    always_comb begin
        s_next            = s_reg;
        s_next.call_start = 1'b0;
        s_next.phase      = mc_end ? 4'h0 : 4'(s_reg.phase + 4'h1);
        s_next.sync_a     = {s_reg.sync_a[0], ext_irq_pin_a};
        s_next.sync_b     = {s_reg.sync_b[0], ext_irq_pin_b};
        if (mc_end) begin
            s_next.sample = s_reg.flags; // [RQ19]
        end
        flags_v = s_reg.flags;
        if (grant) begin
            if (win_info.vec == src_info(4'(TA)).vec) begin
                flags_v[TA] = 1'b0; // [RQ5]
            end
            if (win_info.vec == src_info(4'(TB)).vec) begin
                flags_v[TB] = 1'b0; // [RQ5]
            end
            if (win_info.vec == src_info(4'(IA)).vec && ext_a_edge_mode) begin
                flags_v[IA] = 1'b0; // [RQ6]
            end
            if (win_info.vec == src_info(4'(IB)).vec && ext_b_edge_mode) begin
                flags_v[IB] = 1'b0; // [RQ6]
            end
            // Other flags stay set for software to clear, except level-mode external flags, which follow the pin [RQ7]
        end
        // Software write after hardware clear, hardware set last so it wins
        flags_v = (flags_v & ~sw_flag_wr) | (sw_flag_data & sw_flag_wr); // [RQ24]
        flags_v = flags_v | (hw_event & ~EXT_MASK);
        if (c3) begin
            s_next.samp_a = s_reg.sync_a[1]; // [RQ18]
            s_next.samp_b = s_reg.sync_b[1]; // [RQ18]
            if (ext_a_edge_mode) begin
                flags_v[IA] = flags_v[IA] | (s_reg.samp_a & ~s_reg.sync_a[1]);
            end else begin
                flags_v[IA] = ~s_reg.sync_a[1]; // [RQ6]
            end
            if (ext_b_edge_mode) begin
                flags_v[IB] = flags_v[IB] | (s_reg.samp_b & ~s_reg.sync_b[1]);
            end else begin
                flags_v[IB] = ~s_reg.sync_b[1]; // [RQ6]
            end
        end else begin
            // Level mode flag only moves with the pin sample
            if (!ext_a_edge_mode) begin
                flags_v[IA] = s_reg.flags[IA];
            end
            if (!ext_b_edge_mode) begin
                flags_v[IB] = s_reg.flags[IB];
            end
        end
        s_next.flags = flags_v;
        // Plain subroutine exit is never signalled here [RQ11]
        isr_v = s_reg.in_service;
        if (core.service_exit && top_w[2]) begin
            isr_v[top_w[1:0]] = 1'b0; // [RQ10] [RQ25]
        end
        if (grant) begin
            isr_v[win_lvl] = 1'b1; // [RQ25]
        end
        s_next.in_service = isr_v;
        case (s_reg.fsm)
            flvic_pkg::FLVIC_IDLE: begin
                if (grant) begin
                    s_next.fsm         = flvic_pkg::FLVIC_CALL;
                    s_next.call_start  = 1'b1;
                    s_next.call_active = 1'b1;
                    s_next.call_cnt    = 4'h0;
                    s_next.call_vector = win_info.vec; // [RQ8] [RQ9]
                    s_next.call_level  = win_lvl;
                end
            end
            flvic_pkg::FLVIC_CALL: begin
                if (mc_end) begin
                    if (s_reg.call_cnt == CNT_END) begin
                        s_next.fsm         = flvic_pkg::FLVIC_IDLE; // [RQ20]
                        s_next.call_active = 1'b0;
                    end else begin
                        s_next.call_cnt = 4'(s_reg.call_cnt + 4'h1);
                    end
                end
            end
            default: begin
                s_next.fsm         = flvic_pkg::FLVIC_IDLE;
                s_next.call_active = 1'b0;
            end
        endcase
        s_next.wake_up = (core.power_down & wake_pd) | (core.idle & wake_any); // [RQ17] [RQ22]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign flags       = s_reg.flags;
    assign call_start  = s_reg.call_start;
    assign call_active = s_reg.call_active;
    assign call_vector = s_reg.call_vector;
    assign in_service  = s_reg.in_service;
    assign wake_up     = s_reg.wake_up;

    // Helper: clocks spent in the inserted call
    logic [8:0] act_cnt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            act_cnt <= 9'h000;
        end else begin
            act_cnt <= s_reg.call_active ? 9'(act_cnt + 9'h001) : 9'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_only_last_cycle: assert property (call_start |-> $past(core.last_cycle)) // [RQ2]
        else $error("call inserted outside final machine cycle");
    a_no_block_instr: assert property (call_start |-> !$past(core.blocking_instr)) // [RQ3]
        else $error("call inserted after blocking instruction");
    a_higher_preempts: assert property (call_start |->
        (!$past(top_w[2]) || call_level_gt($past(top_w[1:0])))) // [RQ13]
        else $error("call preempted equal or higher level");
    a_global_gates: assert property (call_start |-> $past(global_en)) // [RQ23]
        else $error("call with global enable clear");
    a_call_length: assert property ($fell(call_active) |-> act_cnt == 9'(CALL_TOTAL)) // [RQ20]
        else $error("inserted call length wrong");
    a_timer_cleared: assert property ((call_start && call_vector == src_info(4'(TA)).vec
        && !$past(hw_event[TA]) && !$past(sw_flag_wr[TA])) |-> !flags[TA]) // [RQ5]
        else $error("timer flag not cleared on vectoring");
    a_uart_kept: assert property ((call_start && $past(flags[RX]) && !$past(sw_flag_wr[RX]))
        |-> flags[RX]) // [RQ7]
        else $error("uart flag cleared by vectoring");
    a_exit_clears_top: assert property ((core.service_exit && top_w[2])
        |=> !in_service[$past(top_w[1:0])]) // [RQ25]
        else $error("service exit left top level set");
    a_level_follows: assert property (($past(c3) && !ext_a_edge_mode && $past(!ext_a_edge_mode))
        |-> flags[IA] == ~s_reg.samp_a) // [RQ6]
        else $error("level mode flag not inverse of pin");
    a_isr_marked: assert property (call_start |-> in_service[s_reg.call_level]) // [RQ25]
        else $error("in-service bit not set on vectoring");

    function automatic logic call_level_gt(input logic [1:0] old_lvl);
        return s_reg.call_level > old_lvl;
    endfunction : call_level_gt

    c_timer_call: cover property (call_start && call_vector == src_info(4'(TA)).vec);
    c_nested_call: cover property (call_start && $past(top_w[2]));
    c_service_exit: cover property (core.service_exit && top_w[2]);
    c_wake: cover property ($rose(wake_up) && core.power_down);
endmodule : flvic_ctrl

// ==== flvic_core_model.sv ====
// Purpose: Core-side model: stack, exit instructions, boundary levels
// Assumes: Bench drives boundary and mode levels through cmd
// Notes:   No underflow guard, so a stray exit is still seen
module flvic_core_model (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire flvic_pkg::flvic_core_s cmd,
    input  wire logic                   call_start,
    input  wire logic [15:0]            call_vector,
    input  wire logic                   ret_req,
    input  wire logic                   ret_plain,
    output flvic_pkg::flvic_core_s      core,
    output logic [15:0]                 pc
);
    logic [15:0] stack [0:7];
    logic [2:0]  sp_reg;
    logic        exit_reg;
    always_ff @(posedge clk) begin
        exit_reg <= 1'b0;
        if (!rst_n) begin
            pc     <= 16'h0100;
            sp_reg <= 3'h0;
        end else if (call_start) begin
            stack[sp_reg] <= pc;
            pc            <= call_vector;
            sp_reg        <= sp_reg + 3'h1;
        end else if (ret_req) begin
            pc       <= stack[sp_reg - 3'h1];
            sp_reg   <= sp_reg - 3'h1;
            exit_reg <= !ret_plain;
        end
    end
    always_comb begin
        core                = cmd;
        core.service_exit   = exit_reg;
        core.blocking_instr = cmd.blocking_instr | exit_reg;
    end
endmodule : flvic_core_model

// ==== testbench.sv ====
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Core model holds last_cycle high unless a scenario drops it
// Notes:   A silent window of several machine cycles proves a withheld call
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0]  POS [0:12] = '{4'h0, 4'h5, 4'hC, 4'h1, 4'h8, 4'h6, 4'h2, 4'h9, 4'hA, 4'h3, 4'hB, 4'h4, 4'hD};
    localparam logic [15:0] VEC [0:12] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
        16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
    logic                   clk, rst_n, pin_a, pin_b, edge_a, edge_b, rc_clk, ret_req, ret_plain;
    logic                   call_start, call_active, wake_up;
    logic [13:0]            hw_event, sw_wr, sw_data, flags;
    logic [15:0]            call_vector, pc;
    logic [3:0]             in_service;
    flvic_pkg::flvic_sfr_s  sfr;
    flvic_pkg::flvic_core_s cmd, core;
    int                     errors = 0;
    int                     checks_done = 0;
    flvic_ctrl flvic_ctrl_i (.clk(clk), .rst_n(rst_n), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .ext_a_edge_mode(edge_a), .ext_b_edge_mode(edge_b), .converter_rc_clock(rc_clk), .sfr(sfr),
        .core(core), .hw_event(hw_event), .sw_flag_wr(sw_wr), .sw_flag_data(sw_data), .flags(flags),
        .call_start(call_start), .call_active(call_active), .call_vector(call_vector),
        .in_service(in_service), .wake_up(wake_up));
    flvic_core_model flvic_core_model_i (.clk(clk), .rst_n(rst_n), .cmd(cmd), .call_start(call_start),
        .call_vector(call_vector), .ret_req(ret_req), .ret_plain(ret_plain), .core(core), .pc(pc));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic sw_write(input logic [13:0] m, input logic v);
        sw_wr   = m;
        sw_data = v ? m : 14'h0000;
        tick(1);
        sw_wr = 14'h0000;
        // A full machine cycle lets the poll snapshot drop a flag just cleared
        tick(4);
    endtask : sw_write
    task automatic en_src(input int i, input logic [1:0] lvl);
        logic [2:0] p;
        p = POS[i][2:0];
        if (POS[i][3]) begin
            sfr.en_b[p]              = 1'b1;
            {sfr.hi_b[p], sfr.lo_b[p]} = lvl;
        end else begin
            sfr.en_a[p]              = 1'b1;
            {sfr.hi_a[p], sfr.lo_a[p]} = lvl;
        end
    endtask : en_src
    task automatic clr_all;
        sfr = '{en_a: 8'h80, default: 8'h00};
        sw_write(14'h3FFF, 1'b0);
    endtask : clr_all
    task automatic wait_start(output int n);
        n = 0;
        while (call_start !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
    endtask : wait_start
    task automatic expect_call(input logic [15:0] vec);
        int n;
        wait_start(n);
        check(16'(call_start), 16'h0001);
        check(call_vector, vec);
        tick(1);
        check(pc, vec);
    endtask : expect_call
    task automatic expect_quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            seen = seen | call_start;
        end
        check(16'(seen), 16'h0000);
    endtask : expect_quiet
    task automatic do_exit(input logic plain);
        ret_req   = 1'b1;
        ret_plain = plain;
        tick(1);
        ret_req = 1'b0;
        tick(2);
    endtask : do_exit
    task automatic t_vectors;
        for (int i = 0; i < 13; i++) begin
            en_src(i, 2'h0);
            sw_write(14'h0001 << i, 1'b1);
            expect_call(VEC[i]);
            check(16'(in_service), 16'h0001);
            check(16'(flags[i]), (i == 0 || i == 3 || i == 6 || i == 9) ? 16'h0000 : 16'h0001);
            clr_all();
            do_exit(1'b0);
            check(16'(in_service), 16'h0000);
        end
    endtask : t_vectors
    task automatic t_levels;
        en_src(5, 2'h1);
        en_src(2, 2'h1);
        sw_write(14'h0024, 1'b1);
        expect_call(16'h0053);
        check(16'(in_service), 16'h0002);
        clr_all();
        do_exit(1'b0);
        en_src(1, 2'h0);
        en_src(12, 2'h3);
        en_src(4, 2'h3);
        sw_write(14'h1002, 1'b1);
        expect_call(16'h0073);
        sw_write(14'h0010, 1'b1);
        expect_quiet(40);
        sw_write(14'h1000, 1'b0);
        do_exit(1'b0);
        expect_call(16'h0033);
        clr_all();
        do_exit(1'b0);
        en_src(3, 2'h1);
        en_src(9, 2'h1);
        en_src(11, 2'h2);
        sw_write(14'h0008, 1'b1);
        expect_call(16'h000B);
        sw_write(14'h0200, 1'b1);
        expect_quiet(40);
        sw_write(14'h0800, 1'b1);
        expect_call(16'h0023);
        check(16'(in_service), 16'h0006);
        sw_write(14'h0800, 1'b0);
        do_exit(1'b0);
        check(16'(in_service), 16'h0002);
        do_exit(1'b0);
        expect_call(16'h001B);
        clr_all();
        do_exit(1'b0);
    endtask : t_levels
    task automatic t_withhold;
        en_src(7, 2'h0);
        cmd = '{default: 1'b0};
        sw_write(14'h0080, 1'b1);
        expect_quiet(24);
        cmd = '{last_cycle: 1'b1, blocking_instr: 1'b1, default: 1'b0};
        expect_quiet(24);
        cmd = '{last_cycle: 1'b1, default: 1'b0};
        sfr.en_a[7] = 1'b0;
        expect_quiet(24);
        sw_write(14'h0080, 1'b0);
        check(16'(flags[7]), 16'h0000);
        sfr.en_a[7] = 1'b1;
        expect_quiet(24);
        sw_write(14'h0080, 1'b1);
        expect_call(16'h003B);
        sw_write(14'h0080, 1'b0);
        do_exit(1'b1);
        check(pc, 16'h0100);
        check(16'(in_service), 16'h0001);
        do_exit(1'b0);
        check(16'(in_service), 16'h0000);
        clr_all();
    endtask : t_withhold
    task automatic t_pins;
        int n;
        edge_a = 1'b0;
        pin_a  = 1'b0;
        tick(16);
        check(16'(flags[0]), 16'h0001);
        en_src(0, 2'h0);
        expect_call(16'h0003);
        check(16'(flags[0]), 16'h0001);
        pin_a = 1'b1;
        tick(16);
        check(16'(flags[0]), 16'h0000);
        do_exit(1'b0);
        en_src(3, 2'h0);
        hw_event[3] = 1'b1;
        tick(1);
        hw_event[3] = 1'b0;
        wait_start(n);
        check(16'(n >= 5 && n <= 48), 16'h0001);
        n = 0;
        while (call_active === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(16'(n), 16'h0010);
        check(16'(flags[3]), 16'h0000);
        do_exit(1'b0);
        clr_all();
    endtask : t_pins
    task automatic t_wake;
        cmd = '{power_down: 1'b1, default: 1'b0};
        en_src(3, 2'h0);
        en_src(7, 2'h0);
        sw_write(14'h0008, 1'b1);
        check(16'(wake_up), 16'h0000);
        sw_write(14'h0080, 1'b1);
        check(16'(wake_up), 16'h0001);
        clr_all();
        cmd = '{last_cycle: 1'b1, default: 1'b0};
    endtask : t_wake
    task automatic finish_test;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Under 1000 cycles are needed; the 20000-cycle limit leaves a wide margin
    initial begin
        #100000;
        errors++;
        finish_test();
    end
    initial begin
        rst_n     = 1'b0;
        pin_a     = 1'b1;
        pin_b     = 1'b1;
        edge_a    = 1'b1;
        edge_b    = 1'b1;
        rc_clk    = 1'b0;
        ret_req   = 1'b0;
        ret_plain = 1'b0;
        hw_event  = 14'h0000;
        sw_wr     = 14'h0000;
        sw_data   = 14'h0000;
        sfr       = '{en_a: 8'h80, default: 8'h00};
        cmd       = '{last_cycle: 1'b1, default: 1'b0};
        tick(4);
        rst_n = 1'b1;
        tick(2);
        t_vectors();
        t_levels();
        t_withhold();
        t_pins();
        t_wake();
        finish_test();
    end
endmodule : testbench
